// >>> rtl/sfpi_pkg.sv
// package: constants and types of the serial flash pin interface
package sfpi_pkg;

  // ====================
  // clock and timing
  localparam int CLK_MHZ            = 100;
  localparam int RESET_PULSE_MIN_NS = 200;
  localparam int RESET_PULSE_MIN_CYC =
    (RESET_PULSE_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int INIT_TIME_NS       = 300000;
  localparam int INSTR_BITS         = 8;

  // ====================
  // register byte offsets
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_TX_DATA  = 8'h04;
  localparam logic [7:0] OFS_RX_DATA  = 8'h08;
  localparam logic [7:0] OFS_INSTR    = 8'h0C;
  localparam logic [7:0] OFS_STATUS   = 8'h10;
  localparam logic [7:0] OFS_CONFIG   = 8'h14;
  localparam logic [7:0] OFS_STATE    = 8'h18;
  localparam logic [7:0] OFS_BANK     = 8'h1C;
  localparam logic [7:0] OFS_PROG_BUF = 8'h20;
  localparam logic [7:0] OFS_OP_BUSY  = 8'h24;

  // ====================
  // field positions
  localparam int SR_LOCK_BIT      = 7;
  localparam int SR_GUARD_LO      = 2;
  localparam int CR_QUAD_BIT      = 1;
  localparam int CR_FROM_TOP_BIT  = 5;
  localparam int ST_READY_BIT     = 0;
  localparam int ST_SELECTED_BIT  = 1;
  localparam int ST_HOLD_BIT      = 2;
  localparam int ST_BUSY_BIT      = 3;
  localparam int ST_ACTIVE_BIT    = 4;
  localparam int ST_REJECT_BIT    = 5;
  localparam int ST_QUAD_BIT      = 6;

  // ====================
  // reset values and masks
  localparam logic [7:0]  SR_RESET      = 8'h00;
  localparam logic [7:0]  CR_RESET      = 8'h00;
  localparam logic [7:0]  SR_VOL_MASK   = 8'h03;
  localparam logic [7:0]  CR_VOL_MASK   = 8'hC0;
  localparam logic [7:0]  BANK_RESET    = 8'h00;
  localparam logic [31:0] PROG_BUF_FILL = 32'hFFFFFFFF;
  localparam logic [31:0] TX_RESET      = 32'h00000000;

  // ====================
  // types
  typedef enum logic [2:0] {
    LM_SINGLE,
    LM_DUAL_OUT,
    LM_QUAD_OUT,
    LM_DUAL_IO,
    LM_QUAD_IO
  } sfpi_lane_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_INSTR,
    ST_IN,
    ST_OUT
  } sfpi_state_t;

  typedef struct packed {
    logic [5:0] in_bits;
    logic       ddr;
    sfpi_lane_t mode;
  } sfpi_ctrl_t;

  typedef struct packed {
    logic       init_n;
    logic       cs_n;
    logic       sck;
    logic [3:0] io;
  } sfpi_pins_t;

  localparam sfpi_ctrl_t CTRL_RESET =
    '{in_bits: 6'h00, ddr: 1'b0, mode: LM_SINGLE};
  localparam sfpi_pins_t PINS_IDLE =
    '{init_n: 1'b1, cs_n: 1'b1, sck: 1'b0, io: 4'hF};

endpackage

// >>> rtl/sfpi_top.sv
// top: pin-level interface logic of a multi-lane serial flash port
//
// The address map and register access over Wishbone were left to the implementer.
`timescale 1ns/1ns
// Functional notes
// - single commands: host sends on lane 0, data returns on lane 1
// - dual/quad output: host sends on lane 0, data on 2 or 4 lanes
// - dual/quad io: both directions use 2 or 4 lanes
// - long init pulse aborts work, floats outputs, clears volatile bits
// - init also zeroes bank, fills program buffer, returns to standby
// - init equals power-up, takes init time, accepted any moment; here init keeps ctrl, tx/rx data and non-volatile bits
// - sample on rising sck; drive after falling, or every edge in ddr
// - select high: inputs ignored, outputs floating
// - select high and no embedded op is standby, else active
// - no command starts without a select falling edge after init
// - guard low with write lock set rejects status/config writes
// - quad mode frees guard pin as data lane 2
// - hold starts at pause low once sck is low, select low
// - hold ends at pause high once sck is low
// - in hold output floats, sck and input ignored, state kept
// - select high during hold resets the interface
// - pause never aborts an embedded operation
// - quad mode frees pause pin as data lane 3
// - lanes 0 and 1 are bidirectional in dual and quad commands
// - lane 0 is group lsb; groups go msb first
// - every command opens with 8 instruction bits on lane 0, rising
module sfpi_top #(
  parameter int INIT_TIME_NS = sfpi_pkg::INIT_TIME_NS
) (
  input  logic        clk_i,
  input  logic        rst_i,
  input  logic        wb_cyc_i,
  input  logic        wb_stb_i,
  input  logic        wb_we_i,
  input  logic [3:0]  wb_sel_i,
  input  logic [7:0]  wb_adr_i,
  input  logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic        wb_ack_o,
  input  logic        sck_i,
  input  logic        cs_n_i,
  input  logic        hard_init_n_i,
  input  logic [3:0]  io_i,
  output logic [3:0]  io_o,
  output logic [3:0]  io_oe_n_o,
  output logic        active_power_o,
  output logic        ready_o
);

  // ====================
  // timing counts
  localparam int INIT_CYC_RAW =
    (INIT_TIME_NS * sfpi_pkg::CLK_MHZ + 999) / 1000;
  localparam int INIT_CYC = (INIT_CYC_RAW < 1) ? 1 : INIT_CYC_RAW;
  localparam logic [7:0] RP_CYC = 8'(sfpi_pkg::RESET_PULSE_MIN_CYC);

  // ====================
  // lane helpers
  function automatic logic [2:0] out_width(sfpi_pkg::sfpi_lane_t m);
    case (m)
      sfpi_pkg::LM_DUAL_OUT,
      sfpi_pkg::LM_DUAL_IO:  out_width = 3'd2;
      sfpi_pkg::LM_QUAD_OUT,
      sfpi_pkg::LM_QUAD_IO:  out_width = 3'd4;
      default:               out_width = 3'd1;
    endcase
  endfunction

  function automatic logic [2:0] in_width(sfpi_pkg::sfpi_lane_t m);
    case (m)
      sfpi_pkg::LM_DUAL_IO: in_width = 3'd2;
      sfpi_pkg::LM_QUAD_IO: in_width = 3'd4;
      default:              in_width = 3'd1;
    endcase
  endfunction

  // ====================
  // declarations
  sfpi_pkg::sfpi_pins_t  pin_meta_r;
  sfpi_pkg::sfpi_pins_t  pin_r;
  sfpi_pkg::sfpi_ctrl_t  ctrl_r;
  sfpi_pkg::sfpi_state_t state_r;
  logic        sck_prev_r;
  logic        cs_n_prev_r;
  logic [7:0]  low_cnt_r;
  logic [31:0] init_cnt_r;
  logic        hw_init;
  logic        init_go;
  logic        ready;
  logic        ready_r;
  logic        quad_en;
  logic        selected;
  logic        pause_n;
  logic        wp_n;
  logic        hold_r;
  logic        hold_nxt;
  logic        sck_rise;
  logic        sck_fall;
  logic        cs_fall;
  logic [2:0]  in_w;
  logic [2:0]  out_w;
  logic        in_ev;
  logic        drive_ev;
  logic        in_on_r;
  logic        out_on_r;
  logic [5:0]  bits_left_r;
  logic [7:0]  instr_r;
  logic [31:0] rx_r;
  logic [31:0] tx_data_r;
  logic [31:0] out_sr_r;
  logic [3:0]  io_o_r;
  logic [3:0]  io_oe_n_r;
  logic [3:0]  lane_mask;
  logic [7:0]  status_r;
  logic [7:0]  config_r;
  logic [7:0]  bank_r;
  logic [31:0] prog_buf_r;
  logic        busy_r;
  logic        reject_r;
  logic        active_r;
  logic        wb_take;
  logic        wb_wr;
  logic        reg_wr;
  logic        guard;
  logic        ack_r;
  logic [31:0] dat_r;
  logic [31:0] rd_val;
  logic [31:0] wr_val;

  // ====================
  // pin synchronisers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_meta_r  <= sfpi_pkg::PINS_IDLE;
      pin_r       <= sfpi_pkg::PINS_IDLE;
      sck_prev_r  <= 1'b0;
      cs_n_prev_r <= 1'b1;
    end else begin
      pin_meta_r  <= '{init_n: hard_init_n_i, cs_n: cs_n_i,
                       sck: sck_i, io: io_i};
      pin_r       <= pin_meta_r;
      sck_prev_r  <= pin_r.sck;
      cs_n_prev_r <= pin_r.cs_n;
    end
  end

  // ====================
  // hard init filter and init timer
  // glitches below the minimum never reach the counter limit
  assign hw_init = (low_cnt_r == RP_CYC);
  assign init_go = rst_i | hw_init;
  assign ready   = (init_cnt_r == 32'h0);

  always_ff @(posedge clk_i) begin
    if (rst_i || pin_r.init_n) begin
      low_cnt_r <= 8'h00;
    end else if (!hw_init) begin
      low_cnt_r <= low_cnt_r + 8'h01;
    end
  end

  // held low keeps reloading, so init runs on from release
  always_ff @(posedge clk_i) begin
    if (init_go) begin
      init_cnt_r <= 32'(INIT_CYC);
    end else if (!ready) begin
      init_cnt_r <= init_cnt_r - 32'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ready_r <= 1'b0;
    end else begin
      ready_r <= ready & ~hw_init;
    end
  end

  // ====================
  // select, hold and clock edges
  assign quad_en  = config_r[sfpi_pkg::CR_QUAD_BIT];
  assign selected = ready & ~pin_r.cs_n;
  assign pause_n  = pin_r.io[3];
  assign wp_n     = pin_r.io[2];
  assign cs_fall  = ready & cs_n_prev_r & ~pin_r.cs_n;

  always_comb begin
    hold_nxt = hold_r;
    if (!selected || quad_en) begin
      hold_nxt = 1'b0;
    end else if (!pin_r.sck) begin
      hold_nxt = ~pause_n;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hold_r <= 1'b0;
    end else begin
      hold_r <= hold_nxt;
    end
  end

  // edges vanish in hold so no counter or shifter moves
  assign sck_rise = selected & ~hold_nxt & pin_r.sck & ~sck_prev_r;
  assign sck_fall = selected & ~hold_nxt & ~pin_r.sck & sck_prev_r;

  assign in_w  = in_width(ctrl_r.mode);
  assign out_w = out_width(ctrl_r.mode);
  // ddr input starts on the first rise after the instruction
  assign in_ev = (state_r == sfpi_pkg::ST_IN)
               & (sck_rise | (ctrl_r.ddr & in_on_r & sck_fall));
  // first output always follows a fall; ddr then uses both edges
  assign drive_ev = (state_r == sfpi_pkg::ST_OUT)
                  & (sck_fall | (ctrl_r.ddr & out_on_r & sck_rise));

  // ====================
  // command sequencer
  always_ff @(posedge clk_i) begin
    if (init_go || !selected) begin
      state_r     <= sfpi_pkg::ST_IDLE;
      bits_left_r <= 6'h00;
      in_on_r     <= 1'b0;
      out_on_r    <= 1'b0;
    end else begin
      case (state_r)
        sfpi_pkg::ST_IDLE: begin
          if (cs_fall) begin
            state_r     <= sfpi_pkg::ST_INSTR;
            bits_left_r <= 6'(sfpi_pkg::INSTR_BITS);
          end
        end
        sfpi_pkg::ST_INSTR: begin
          if (sck_rise) begin
            if (bits_left_r == 6'h01) begin
              bits_left_r <= ctrl_r.in_bits;
              if (ctrl_r.in_bits == 6'h00) begin
                state_r <= sfpi_pkg::ST_OUT;
              end else begin
                state_r <= sfpi_pkg::ST_IN;
              end
            end else begin
              bits_left_r <= bits_left_r - 6'h01;
            end
          end
        end
        sfpi_pkg::ST_IN: begin
          if (in_ev) begin
            in_on_r <= 1'b1;
            if (bits_left_r <= {3'b000, in_w}) begin
              state_r <= sfpi_pkg::ST_OUT;
            end else begin
              bits_left_r <= bits_left_r - {3'b000, in_w};
            end
          end
        end
        sfpi_pkg::ST_OUT: begin
          if (drive_ev) begin
            out_on_r <= 1'b1;
          end
        end
        default: begin
          state_r <= sfpi_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ====================
  // captured instruction and input data
  // kept after deselect so software can read the last command
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      instr_r <= 8'h00;
      rx_r    <= 32'h0;
    end else if (state_r == sfpi_pkg::ST_IDLE && cs_fall) begin
      instr_r <= 8'h00;
      rx_r    <= 32'h0;
    end else if (state_r == sfpi_pkg::ST_INSTR && sck_rise) begin
      instr_r <= {instr_r[6:0], pin_r.io[0]};
    end else if (in_ev) begin
      case (in_w)
        3'd4:    rx_r <= {rx_r[27:0], pin_r.io};
        3'd2:    rx_r <= {rx_r[29:0], pin_r.io[1:0]};
        default: rx_r <= {rx_r[30:0], pin_r.io[0]};
      endcase
    end
  end

  // ====================
  // output lanes
  // lanes 2 and 3 stay guard and pause pins unless quad is on
  always_comb begin
    case (out_w)
      3'd4:    lane_mask = quad_en ? 4'h0 : 4'hC;
      3'd2:    lane_mask = 4'hC;
      default: lane_mask = 4'hD;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (init_go) begin
      out_sr_r  <= 32'h0;
      io_o_r    <= 4'h0;
      io_oe_n_r <= 4'hF;
    end else begin
      if (state_r != sfpi_pkg::ST_OUT) begin
        out_sr_r <= tx_data_r;
      end else if (drive_ev) begin
        case (out_w)
          3'd4: begin
            io_o_r   <= out_sr_r[31:28];
            out_sr_r <= {out_sr_r[27:0], 4'h0};
          end
          3'd2: begin
            io_o_r   <= {2'b00, out_sr_r[31:30]};
            out_sr_r <= {out_sr_r[29:0], 2'b00};
          end
          default: begin
            io_o_r   <= {2'b00, out_sr_r[31], 1'b0};
            out_sr_r <= {out_sr_r[30:0], 1'b0};
          end
        endcase
      end
      if ((state_r == sfpi_pkg::ST_OUT) && (out_on_r | drive_ev)
          && selected && !hold_nxt) begin
        io_oe_n_r <= lane_mask;
      end else begin
        io_oe_n_r <= 4'hF;
      end
    end
  end

  // ====================
  // status and configuration
  assign reg_wr = wb_wr & ((wb_adr_i == sfpi_pkg::OFS_STATUS)
                         | (wb_adr_i == sfpi_pkg::OFS_CONFIG));
  assign guard  = ~quad_en & ~wp_n
                & status_r[sfpi_pkg::SR_LOCK_BIT];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_r <= sfpi_pkg::SR_RESET;
      config_r <= sfpi_pkg::CR_RESET;
    end else if (hw_init) begin
      status_r <= status_r & ~sfpi_pkg::SR_VOL_MASK;
      config_r <= config_r & ~sfpi_pkg::CR_VOL_MASK;
    end else if (reg_wr && !guard) begin
      if (wb_adr_i == sfpi_pkg::OFS_STATUS) begin
        status_r <= wr_val[7:0];
      end else begin
        config_r <= wr_val[7:0];
      end
    end
  end

  // a rejection in the clearing cycle still sticks
  always_ff @(posedge clk_i) begin
    if (init_go) begin
      reject_r <= 1'b0;
    end else if (reg_wr && guard) begin
      reject_r <= 1'b1;
    end else if (wb_wr && wb_adr_i == sfpi_pkg::OFS_STATE
                 && wr_val[sfpi_pkg::ST_REJECT_BIT]) begin
      reject_r <= 1'b0;
    end
  end

  // ====================
  // bank, program buffer and embedded operation
  // pause is not looked at here, so hold cannot abort an operation
  always_ff @(posedge clk_i) begin
    if (init_go) begin
      bank_r     <= sfpi_pkg::BANK_RESET;
      prog_buf_r <= sfpi_pkg::PROG_BUF_FILL;
      busy_r     <= 1'b0;
    end else if (wb_wr) begin
      case (wb_adr_i)
        sfpi_pkg::OFS_BANK:     bank_r     <= wr_val[7:0];
        sfpi_pkg::OFS_PROG_BUF: prog_buf_r <= wr_val;
        sfpi_pkg::OFS_OP_BUSY:  busy_r     <= wr_val[0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      active_r <= 1'b0;
    end else begin
      active_r <= ~pin_r.cs_n | busy_r;
    end
  end

  // ====================
  // software control
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r    <= sfpi_pkg::CTRL_RESET;
      tx_data_r <= sfpi_pkg::TX_RESET;
    end else if (wb_wr) begin
      case (wb_adr_i)
        sfpi_pkg::OFS_CTRL:    ctrl_r    <= sfpi_pkg::sfpi_ctrl_t'(wr_val[9:0]);
        sfpi_pkg::OFS_TX_DATA: tx_data_r <= wr_val;
        default: ;
      endcase
    end
  end

  // ====================
  // wishbone slave
  assign wb_take = wb_cyc_i & wb_stb_i & ~ack_r;
  assign wb_wr   = wb_take & wb_we_i;

  always_comb begin
    rd_val = 32'h0;
    case (wb_adr_i)
      sfpi_pkg::OFS_CTRL:     rd_val = {22'h0, ctrl_r};
      sfpi_pkg::OFS_TX_DATA:  rd_val = tx_data_r;
      sfpi_pkg::OFS_RX_DATA:  rd_val = rx_r;
      sfpi_pkg::OFS_INSTR:    rd_val = {24'h0, instr_r};
      sfpi_pkg::OFS_STATUS:   rd_val = {24'h0, status_r};
      sfpi_pkg::OFS_CONFIG:   rd_val = {24'h0, config_r};
      sfpi_pkg::OFS_BANK:     rd_val = {24'h0, bank_r};
      sfpi_pkg::OFS_PROG_BUF: rd_val = prog_buf_r;
      sfpi_pkg::OFS_OP_BUSY:  rd_val = {31'h0, busy_r};
      sfpi_pkg::OFS_STATE: begin
        rd_val[sfpi_pkg::ST_READY_BIT]    = ready;
        rd_val[sfpi_pkg::ST_SELECTED_BIT] = selected;
        rd_val[sfpi_pkg::ST_HOLD_BIT]     = hold_r;
        rd_val[sfpi_pkg::ST_BUSY_BIT]     = busy_r;
        rd_val[sfpi_pkg::ST_ACTIVE_BIT]   = active_r;
        rd_val[sfpi_pkg::ST_REJECT_BIT]   = reject_r;
        rd_val[sfpi_pkg::ST_QUAD_BIT]     = quad_en;
      end
      default: rd_val = 32'h0;
    endcase
  end

  // unselected byte lanes keep their present contents
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wr_val[8*b +: 8] = wb_sel_i[b] ? wb_dat_i[8*b +: 8]
                                     : rd_val[8*b +: 8];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0;
    end else begin
      ack_r <= wb_take;
      if (wb_take && !wb_we_i) begin
        dat_r <= rd_val;
      end
    end
  end

  // ====================
  // outputs
  assign wb_ack_o       = ack_r;
  assign wb_dat_o       = dat_r;
  assign io_o           = io_o_r;
  assign io_oe_n_o      = io_oe_n_r;
  assign active_power_o = active_r;
  assign ready_o        = ready_r;

endmodule

// >>> dv/sfpi_host_model.sv
// host model: drives select, clock and lanes of the flash port
`timescale 1ns/1ns
module sfpi_host_model (
  input  logic [3:0] dev_o_i,
  input  logic [3:0] dev_oe_n_i,
  output logic       sck_o,
  output logic       cs_n_o,
  output logic [3:0] io_o
);
  localparam int HALF = 62;
  // high phase one longer, so a clock period is 125 ns
  localparam int HALF_HI = 63;
  logic [3:0] hdrv;
  logic [3:0] hval;
  logic [3:0] last;
  logic       quad;
  logic       guard_n;
  logic       pause_n;
  // ====================
  // wire resolution
  // lanes 2/3 pulled up in quad, else carry guard_n/pause_n; a released lane 0/1 shows the inverse, not stale
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      if (!dev_oe_n_i[k]) io_o[k] = dev_o_i[k];
      else if (hdrv[k]) io_o[k] = hval[k];
      else if (k == 2) io_o[k] = quad | guard_n;
      else if (k == 3) io_o[k] = quad | pause_n;
      else io_o[k] = ~last[k];
    end
  end
  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    hdrv = 4'h0;
    hval = 4'h0;
    last = 4'h0;
    quad = 1'b0;
    guard_n = 1'b1;
    pause_n = 1'b1;
  end
  // ====================
  // transfers, mode 0: data set while low, taken on the rise
  task automatic tick(input logic [3:0] d, input logic [3:0] en);
    hdrv = en;
    hval = d;
    last = d;
    #HALF sck_o = 1'b1;
    #HALF_HI sck_o = 1'b0;
  endtask
  task automatic cmd(input logic [7:0] ins, input logic [7:0] din,
                     input int iw, input int ow, output logic [7:0] dout);
    logic [3:0] m;
    dout = 8'h00;
    cs_n_o = 1'b0;
    for (int i = 7; i >= 0; i--) tick({3'h0, ins[i]}, 4'h1);
    for (int i = 8 - iw; i >= 0; i -= iw)
      tick(4'(din >> i), 4'((1 << iw) - 1));
    hdrv = 4'h0;
    for (int i = 0; i < 8 / ow; i++) begin
      #HALF m = (ow == 1) ? {3'h0, io_o[1]} : io_o & 4'((1 << ow) - 1);
      dout = (dout << ow) | 8'(m);
      sck_o = 1'b1;
      #HALF_HI sck_o = 1'b0;
    end
    cs_n_o = 1'b1;
    #HALF;
  endtask
endmodule

// >>> dv/sfpi_assertions.sv
// checker: concurrent properties on the flash interface ports
`timescale 1ns/1ns
module sfpi_assertions #(
  parameter int INIT_TIME_NS = sfpi_pkg::INIT_TIME_NS
) (
  input logic        clk_i,
  input logic        rst_i,
  input logic        wb_cyc_i,
  input logic        wb_stb_i,
  input logic        wb_ack_o,
  input logic        sck_i,
  input logic        cs_n_i,
  input logic        hard_init_n_i,
  input logic [3:0]  io_i,
  input logic [3:0]  io_o,
  input logic [3:0]  io_oe_n_o,
  input logic        active_power_o,
  input logic        ready_o
);
  localparam int INIT_CYC = INIT_TIME_NS * sfpi_pkg::CLK_MHZ / 1000;
  logic [7:0]  low_cnt_r;
  logic [3:0]  fall_cnt_r;
  logic        sck_d_r;
  logic        long_r;
  logic [19:0] wait_cnt_r;
  // ====================
  // helper counters
  always_ff @(posedge clk_i) begin
    if (rst_i || hard_init_n_i) low_cnt_r <= 8'h00;
    else if (low_cnt_r != 8'hFF) low_cnt_r <= low_cnt_r + 8'h01;
  end
  // sdr only: ddr output timing is not checked here
  always_ff @(posedge clk_i) begin
    sck_d_r <= sck_i;
    if (rst_i || (sck_d_r && !sck_i)) fall_cnt_r <= 4'h0;
    else if (fall_cnt_r != 4'hF) fall_cnt_r <= fall_cnt_r + 4'h1;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i || $rose(ready_o)) long_r <= 1'b0;
    else if (low_cnt_r >= 8'h13) long_r <= 1'b1;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i || !hard_init_n_i) wait_cnt_r <= 20'h00000;
    else if (!ready_o) wait_cnt_r <= wait_cnt_r + 20'h00001;
  end
  // ====================
  // properties
  bus_answer_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus access not answered by one ack");
  cs_float_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
      cs_n_i [*4] |=> io_oe_n_o == 4'hF)
    else $error("lanes driven while deselected");
  init_float_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
      low_cnt_r >= 8'h18 |-> io_oe_n_o == 4'hF)
    else $error("lanes driven during init pulse");
  init_filter_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
      $fell(ready_o) |-> long_r)
    else $error("short init pulse took effect");
  init_time_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(ready_o) |-> wait_cnt_r >= 20'(INIT_CYC)
        && wait_cnt_r <= 20'(INIT_CYC + 8))
    else $error("init time wrong");
  active_power_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
      !cs_n_i [*4] |=> active_power_o)
    else $error("not active while selected");
  drive_edge_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
      ((io_o ^ $past(io_o)) & ~io_oe_n_o & ~$past(io_oe_n_o)) != 4'h0
        |-> fall_cnt_r <= 4'h6)
    else $error("lane changed away from a clock fall");
  hold_float_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
      (!cs_n_i && !io_i[3] && !sck_i && io_oe_n_o[3]) [*5]
        |=> io_oe_n_o[1])
    else $error("output driven in hold");
endmodule
bind sfpi_top sfpi_assertions #(.INIT_TIME_NS(INIT_TIME_NS)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .sck_i(sck_i),
  .cs_n_i(cs_n_i), .hard_init_n_i(hard_init_n_i), .io_i(io_i),
  .io_o(io_o), .io_oe_n_o(io_oe_n_o),
  .active_power_o(active_power_o), .ready_o(ready_o));

// >>> dv/testbench.sv
// testbench: bus and link scenarios for the flash pin interface
`timescale 1ns/1ns
`define CHK(g, e) \
  begin \
    cmp_count++; \
    if ((g) !== (e)) begin \
      failures++; \
      $display("MISMATCH t=%0t got %0h exp %0h", $time, g, e); \
    end \
  end
module testbench;
  logic        clk_i;
  logic        rst_i;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [3:0]  sel;
  logic [7:0]  adr;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic        ack;
  logic        sck;
  logic        cs_n;
  logic        init_n;
  logic [3:0]  io_in;
  logic [3:0]  io_out;
  logic [3:0]  oe_n;
  logic        active;
  logic        ready;
  logic [31:0] q;
  logic [7:0]  got;
  logic [7:0]  tx;
  int          failures;
  int          cmp_count;
  int          cycles;
  int          iw;
  int          ow;
  sfpi_top #(.INIT_TIME_NS(1000)) i_sfpi_top (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_sel_i(sel), .wb_adr_i(adr), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .sck_i(sck), .cs_n_i(cs_n),
    .hard_init_n_i(init_n), .io_i(io_in), .io_o(io_out),
    .io_oe_n_o(oe_n), .active_power_o(active), .ready_o(ready));
  sfpi_host_model i_sfpi_host_model (
    .dev_o_i(io_out), .dev_oe_n_i(oe_n), .sck_o(sck), .cs_n_o(cs_n),
    .io_o(io_in));
  initial clk_i = 1'b0;
  always #5 clk_i = ~clk_i;
  // ====================
  // closing and watchdog
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 30000) begin
      failures++;
      end_of_test();
    end
  end
  // ====================
  // bus and pin tasks
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    // ends on ack; only the watchdog bounds this wait
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    `CHK(ack, 1'b1)
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wait_ready();
    int n;
    n = 0;
    while (ready !== 1'b1 && n < 400) begin
      @(posedge clk_i);
      n++;
    end
    `CHK(ready, 1'b1)
  endtask
  task automatic pulse(input int n);
    @(posedge clk_i);
    init_n <= 1'b0;
    repeat (n) @(posedge clk_i);
    init_n <= 1'b1;
    repeat (4) @(posedge clk_i);
  endtask
  // ====================
  // scenarios
  initial begin
    rst_i = 1'b1;
    {cyc, stb, we, adr, wdat} = '0;
    sel = 4'hF;
    init_n = 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    wait_ready();
    bus(1'b0, 8'h3C, 32'h0);
    `CHK(q, 32'h00000000)
    // every lane mode, 8 bits in and 8 bits out
    for (int m = 0; m < 5; m++) begin
      iw = (m == 3) ? 2 : (m == 4) ? 4 : 1;
      ow = (m == 0) ? 1 : (m == 2 || m == 4) ? 4 : 2;
      tx = 8'hC3 ^ 8'(m * 37);
      i_sfpi_host_model.quad <= (m == 2 || m == 4);
      bus(1'b1, sfpi_pkg::OFS_CONFIG, (m == 2 || m == 4) ? 32'h2 : 32'h0);
      bus(1'b1, sfpi_pkg::OFS_CTRL, 32'h80 | 32'(m));
      bus(1'b1, sfpi_pkg::OFS_TX_DATA, {tx, 24'h000000});
      i_sfpi_host_model.cmd(8'h6B ^ 8'(m), 8'h2D ^ tx, iw, ow, got);
      `CHK(got, tx)
      bus(1'b0, sfpi_pkg::OFS_INSTR, 32'h0);
      `CHK(q[7:0], 8'h6B ^ 8'(m))
      bus(1'b0, sfpi_pkg::OFS_RX_DATA, 32'h0);
      `CHK(q[7:0], 8'h2D ^ tx)
    end
    // write guard, then quad mode overriding it
    // guard pin moves early: it takes two cycles to be seen
    i_sfpi_host_model.quad <= 1'b0;
    bus(1'b1, sfpi_pkg::OFS_CONFIG, 32'h0);
    i_sfpi_host_model.guard_n <= 1'b0;
    bus(1'b1, sfpi_pkg::OFS_STATUS, 32'h80);
    bus(1'b1, sfpi_pkg::OFS_STATUS, 32'h9C);
    bus(1'b0, sfpi_pkg::OFS_STATUS, 32'h0);
    `CHK(q[7:0], 8'h80)
    i_sfpi_host_model.guard_n <= 1'b1;
    bus(1'b0, sfpi_pkg::OFS_STATE, 32'h0);
    `CHK(q[5], 1'b1)
    bus(1'b1, sfpi_pkg::OFS_CONFIG, 32'h2);
    i_sfpi_host_model.quad <= 1'b1;
    i_sfpi_host_model.hdrv <= 4'h4;
    i_sfpi_host_model.hval <= 4'h0;
    bus(1'b1, sfpi_pkg::OFS_STATUS, 32'h9C);
    bus(1'b0, sfpi_pkg::OFS_STATUS, 32'h0);
    `CHK(q[7:0], 8'h9C)
    i_sfpi_host_model.hdrv <= 4'h0;
    i_sfpi_host_model.quad <= 1'b0;
    bus(1'b1, sfpi_pkg::OFS_CONFIG, 32'hC0);
    bus(1'b1, sfpi_pkg::OFS_OP_BUSY, 32'h1);
    // hold with select kept low, embedded op running
    i_sfpi_host_model.cs_n_o <= 1'b0;
    repeat (4) @(posedge clk_i);
    i_sfpi_host_model.pause_n <= 1'b0;
    repeat (4) @(posedge clk_i);
    bus(1'b0, sfpi_pkg::OFS_STATE, 32'h0);
    `CHK(q[2], 1'b1)
    `CHK(q[3], 1'b1)
    `CHK(oe_n, 4'hF)
    i_sfpi_host_model.pause_n <= 1'b1;
    repeat (8) @(posedge clk_i);
    bus(1'b0, sfpi_pkg::OFS_STATE, 32'h0);
    `CHK(q[2], 1'b0)
    i_sfpi_host_model.cs_n_o <= 1'b1;
    // hardware init: short pulse ignored, long pulse reloads
    bus(1'b1, sfpi_pkg::OFS_BANK, 32'h5);
    bus(1'b1, sfpi_pkg::OFS_STATUS, 32'h83);
    repeat (4) @(posedge clk_i);
    `CHK(active, 1'b1)
    pulse(10);
    bus(1'b0, sfpi_pkg::OFS_BANK, 32'h0);
    `CHK(q[7:0], 8'h05)
    pulse(30);
    `CHK(ready, 1'b0)
    wait_ready();
    bus(1'b0, sfpi_pkg::OFS_BANK, 32'h0);
    `CHK(q[7:0], 8'h00)
    bus(1'b0, sfpi_pkg::OFS_STATUS, 32'h0);
    `CHK(q[7:0], 8'h80)
    bus(1'b0, sfpi_pkg::OFS_CONFIG, 32'h0);
    `CHK(q[7:0], 8'h00)
    `CHK(active, 1'b0)
    // single command after init returns the tx data kept through init
    bus(1'b1, sfpi_pkg::OFS_CTRL, 32'h80);
    i_sfpi_host_model.cmd(8'h3B, 8'hA5, 1, 1, got);
    `CHK(got, tx)
    sel <= 4'h2;
    bus(1'b1, sfpi_pkg::OFS_PROG_BUF, 32'h0);
    sel <= 4'hF;
    bus(1'b0, sfpi_pkg::OFS_PROG_BUF, 32'h0);
    `CHK(q, 32'hFFFF00FF)
    end_of_test();
  end
endmodule
